// ===== design/rss_pkg.sv
package rss_pkg;

  localparam int NPORT = 4;
  localparam int NSTRAP = 10;

  // Strap vector layout
  localparam int PIN_PPC = 0;
  localparam int PIN_OCS = 4;
  localparam int PIN_FDO = 8;
  localparam int PIN_JRST = 9;

  // Settle time per pull phase; least time, so rounded up
  localparam int CLK_NS = 5;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // Register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam int BIT_STRAP_EN = 0;
  localparam int BIT_OCS_NO_SW = 1;
  localparam int STAT_PORT_EN = 0;
  localparam int STAT_CHG_EN = 4;
  localparam int STAT_NON_REM = 8;
  localparam int STAT_FAST = 12;
  localparam int STAT_LEGACY = 13;
  localparam int STAT_DONE = 14;
  localparam int STAT_GDIS_N = 15;

  typedef enum logic [1:0] {
    RSS_PH_HI,
    RSS_PH_LO,
    RSS_PH_DONE
  } rss_phase_t;

  typedef struct packed {
    logic ocs_no_sw;
    logic strap_en;
  } rss_ctrl_t;

  localparam rss_ctrl_t CTRL_RST = '{ocs_no_sw: 1'b0, strap_en: 1'b1};

  typedef struct packed {
    logic [NPORT-1:0] port_en;
    logic [NPORT-1:0] chg_en;
    logic [NPORT-1:0] non_rem;
    logic             flash_fast;
    logic             smb_legacy;
    logic             gdis_pu;
  } rss_settings_t;

  typedef struct packed {
    rss_phase_t        phase;
    logic [CNT_W-1:0]  cnt;
    logic [NSTRAP-1:0] samp_hi;
    logic [NSTRAP-1:0] samp_lo;
    logic              done;
    rss_ctrl_t         ctrl;
    rss_settings_t     set;
    logic [31:0]       rdata;
  } rss_state_t;

  localparam rss_state_t STATE_RST = '{
    phase: RSS_PH_HI, cnt: '0, samp_hi: '0, samp_lo: '0, done: 1'b0,
    ctrl: CTRL_RST, set: '0, rdata: 32'h0000_0000};

endpackage

// ===== design/rss_sync.sv
`timescale 1ns/1ps
module rss_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } rss_sync_t;

  rss_sync_t s;
  rss_sync_t next_s;

  // First stage feeds only the second
  always_comb begin
    next_s.meta = d_i;
    next_s.q    = s.meta;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;

endmodule

// ===== design/rss_top.sv
`timescale 1ns/1ps
module rss_top (
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // Strap pins, asynchronous
  input  wire logic [3:0]            port_power_control_i,
  input  wire logic [3:0]            overcurrent_sense_i,
  input  wire logic                  flash_data_out_i,
  input  wire logic                  jtag_reset_i,
  input  wire logic                  charge_port_global_disable_n_i,
  // Strap pull controls
  output logic                       strap_pull_up_o,
  output logic                       strap_pull_down_o,
  // Register port
  input  wire logic [3:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  // Settings to the hub
  output rss_pkg::rss_settings_t     settings_o,
  output logic                       sample_done_o
);

  logic [rss_pkg::NSTRAP:0] raw;
  logic [rss_pkg::NSTRAP:0] pins;
  logic                     gdis_n;

  rss_pkg::rss_state_t s;
  rss_pkg::rss_state_t next_s;

  assign raw = {charge_port_global_disable_n_i, jtag_reset_i, flash_data_out_i,
                overcurrent_sense_i, port_power_control_i};

  rss_sync #(
    .WIDTH (rss_pkg::NSTRAP + 1)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (raw),
    .q_o       (pins)
  );

  assign gdis_n = pins[rss_pkg::NSTRAP];

  always_comb begin
    logic apply;
    logic is_up;
    logic is_dn;
    apply  = 1'b0;
    is_up  = 1'b0;
    is_dn  = 1'b0;
    next_s = s;
    next_s.rdata = 32'h0000_0000;

    if (wr_i && addr_i == rss_pkg::ADDR_CTRL) begin
      next_s.ctrl.strap_en  = wdata_i[rss_pkg::BIT_STRAP_EN];
      next_s.ctrl.ocs_no_sw = wdata_i[rss_pkg::BIT_OCS_NO_SW];
    end

    // Unmapped addresses read as zero
    if (rd_i) begin
      case (addr_i)
        rss_pkg::ADDR_CTRL: begin
          next_s.rdata[rss_pkg::BIT_STRAP_EN]  = s.ctrl.strap_en;
          next_s.rdata[rss_pkg::BIT_OCS_NO_SW] = s.ctrl.ocs_no_sw;
        end
        rss_pkg::ADDR_STAT: begin
          next_s.rdata[rss_pkg::STAT_PORT_EN +: rss_pkg::NPORT] = s.set.port_en;
          next_s.rdata[rss_pkg::STAT_CHG_EN +: rss_pkg::NPORT]  = s.set.chg_en;
          next_s.rdata[rss_pkg::STAT_NON_REM +: rss_pkg::NPORT] = s.set.non_rem;
          next_s.rdata[rss_pkg::STAT_FAST]   = s.set.flash_fast;
          next_s.rdata[rss_pkg::STAT_LEGACY] = s.set.smb_legacy;
          next_s.rdata[rss_pkg::STAT_DONE]   = s.done;
          next_s.rdata[rss_pkg::STAT_GDIS_N] = gdis_n;
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Two pull phases tell floating from driven straps
    // capture at the end of each phase, pull still applied
    case (s.phase)
      rss_pkg::RSS_PH_HI: begin
        if (s.cnt == rss_pkg::SETTLE_LAST) begin
          next_s.samp_hi = pins[rss_pkg::NSTRAP-1:0];
          next_s.cnt     = '0;
          next_s.phase   = rss_pkg::RSS_PH_LO;
        end else begin
          next_s.cnt = s.cnt + rss_pkg::CNT_ONE;
        end
      end
      rss_pkg::RSS_PH_LO: begin
        if (s.cnt == rss_pkg::SETTLE_LAST) begin
          next_s.samp_lo = pins[rss_pkg::NSTRAP-1:0];
          next_s.cnt     = '0;
          next_s.phase   = rss_pkg::RSS_PH_DONE;
          next_s.done    = 1'b1;
        end else begin
          next_s.cnt = s.cnt + rss_pkg::CNT_ONE;
        end
      end
      rss_pkg::RSS_PH_DONE: begin
        next_s.cnt = '0;
      end
      default: begin
        next_s.phase = rss_pkg::RSS_PH_HI;
      end
    endcase

    apply = s.done && s.ctrl.strap_en && !s.ctrl.ocs_no_sw;
    for (int i = 0; i < rss_pkg::NPORT; i++) begin
      is_up = s.samp_hi[rss_pkg::PIN_PPC + i] && s.samp_lo[rss_pkg::PIN_PPC + i];
      is_dn = !s.samp_hi[rss_pkg::PIN_PPC + i] && !s.samp_lo[rss_pkg::PIN_PPC + i];
      next_s.set.port_en[i] = s.done && !(apply && is_dn);
      next_s.set.chg_en[i]  = apply && is_up && gdis_n;
      // pulled down reads low under pull-up
      next_s.set.non_rem[i] = apply && !s.samp_hi[rss_pkg::PIN_OCS + i];
    end
    // pulled up reads high under pull-down
    next_s.set.flash_fast = s.done && s.samp_lo[rss_pkg::PIN_FDO];
    // only a real pull-up wins against pull-down
    next_s.set.smb_legacy = s.done && s.samp_lo[rss_pkg::PIN_JRST];
    next_s.set.gdis_pu    = s.done;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s <= rss_pkg::STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign strap_pull_up_o   = (s.phase == rss_pkg::RSS_PH_HI);
  assign strap_pull_down_o = (s.phase == rss_pkg::RSS_PH_LO);
  assign rdata_o           = s.rdata;
  assign settings_o        = s.set;
  assign sample_done_o     = s.done;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic apply_q;
  assign apply_q = s.done && s.ctrl.strap_en && !s.ctrl.ocs_no_sw;

  strap_hold_a: assert property (
    s.done |=> $stable(s.samp_hi) && $stable(s.samp_lo) && s.done)
    else $error("latched straps changed after sampling");

  port_decode_a: assert property (
    apply_q |=> settings_o.port_en ==
      ~($past(~s.samp_hi[3:0]) & $past(~s.samp_lo[3:0])))
    else $error("port enable decode wrong");

  chg_decode_a: assert property (
    apply_q && gdis_n |=> settings_o.chg_en ==
      ($past(s.samp_hi[3:0]) & $past(s.samp_lo[3:0])))
    else $error("charging decode wrong");

  flash_speed_a: assert property (
    s.done |=> settings_o.flash_fast == $past(s.samp_lo[rss_pkg::PIN_FDO]))
    else $error("flash speed does not follow strap");

  flash_sample_a: assert property (
    s.phase == rss_pkg::RSS_PH_LO && s.cnt == rss_pkg::SETTLE_LAST
      |=> s.samp_lo[rss_pkg::PIN_FDO] == $past(pins[rss_pkg::PIN_FDO]) && s.done)
    else $error("flash strap not captured at end of sampling");

  non_rem_a: assert property (
    apply_q |=> settings_o.non_rem == $past(~s.samp_hi[7:4]))
    else $error("non-removable decode wrong");

  strap_off_a: assert property (
    s.done && !s.ctrl.strap_en |=> settings_o.port_en == 4'hf &&
      settings_o.chg_en == 4'h0 && settings_o.non_rem == 4'h0)
    else $error("straps applied while disabled");

  ocs_only_a: assert property (
    s.ctrl.ocs_no_sw |=> settings_o.chg_en == 4'h0 && settings_o.non_rem == 4'h0)
    else $error("straps applied without power switching");

  late_pullup_a: assert property (
    settings_o.gdis_pu |-> s.phase == rss_pkg::RSS_PH_DONE && !strap_pull_down_o)
    else $error("pull-up enabled before mode sampled");

  smb_mode_a: assert property (
    s.done |=> settings_o.smb_legacy == $past(s.samp_lo[rss_pkg::PIN_JRST]))
    else $error("SMBus mode does not follow strap");

  global_dis_a: assert property (
    !gdis_n |=> settings_o.chg_en == 4'h0)
    else $error("charging on while globally disabled");

  phase_step_a: assert property (
    s.phase == rss_pkg::RSS_PH_HI && s.cnt == rss_pkg::SETTLE_LAST
      |=> s.phase == rss_pkg::RSS_PH_LO && s.samp_hi == $past(pins[rss_pkg::NSTRAP-1:0]))
    else $error("pull-up sample not taken at end of first phase");

  early_off_a: assert property (
    !s.done |=> !settings_o.gdis_pu && settings_o.port_en == 4'h0 &&
      settings_o.chg_en == 4'h0)
    else $error("settings active before sampling finished");

  // Settings may only move with the control word or the global disable
  set_hold_a: assert property (
    s.done && $past(s.done) && $stable(s.ctrl) && $stable(gdis_n) |=> $stable(settings_o))
    else $error("settings changed with no cause after sampling");

  ctrl_read_a: assert property (
    rd_i && addr_i == rss_pkg::ADDR_CTRL |=> rdata_o ==
      {30'h0, $past(s.ctrl.ocs_no_sw), $past(s.ctrl.strap_en)})
    else $error("control readback wrong");

endmodule

// ===== verif/rss_board.sv
`timescale 1ns/1ps
module rss_board (
  // Clock for the floating-pin pattern
  input  wire logic        clk_sys_i,
  // Strap fitting per pin: 0 none, 1 pull-down, 2 pull-up
  input  wire logic [19:0] mode_i,
  // Internal pulls of the device
  input  wire logic        pull_up_i,
  input  wire logic        pull_down_i,
  // Pin levels seen by the device
  output logic      [9:0]  pin_o
);
  logic toggle = 1'b0;

  // Unstrapped pin wanders while neither internal pull is on, so it then never reads as a stable level
  always @(posedge clk_sys_i) begin
    toggle <= ~toggle;
  end

  always_comb begin
    for (int i = 0; i < 10; i++) begin
      case (mode_i[2*i +: 2])
        2'd1: pin_o[i] = 1'b0;
        2'd2: pin_o[i] = 1'b1;
        default: pin_o[i] = pull_up_i ? 1'b1 : (pull_down_i ? 1'b0 : toggle);
      endcase
    end
  end
endmodule

// ===== verif/tb_rss_top.sv
`timescale 1ns/1ps
module tb_rss_top;
  typedef struct packed {
    logic [19:0]            mode;
    logic [1:0]             ctrl;
    logic                   gdis_n;
    rss_pkg::rss_settings_t exp;
  } rss_row_t;
  localparam rss_row_t ROWS [6] = '{
    '{20'h00000, 2'h1, 1'b1, 15'h7801}, '{20'ha4986, 2'h1, 1'b1, 15'h6ccf},
    '{20'ha4986, 2'h0, 1'b1, 15'h7807}, '{20'ha4986, 2'h3, 1'b1, 15'h7807},
    '{20'h55555, 2'h1, 1'b1, 15'h0079}, '{20'ha4986, 2'h1, 1'b0, 15'h684f}};

  logic                   clk_sys_i = 1'b0;
  logic                   rst_i     = 1'b1;
  logic [19:0]            mode      = 20'h00000;
  logic                   gdis_n    = 1'b1;
  logic [3:0]             addr      = 4'h0;
  logic [31:0]            wdata     = 32'h0000_0000;
  logic                   wr        = 1'b0;
  logic                   rd        = 1'b0;
  logic [9:0]             pins;
  logic                   pull_up;
  logic                   pull_down;
  logic [31:0]            rdata;
  rss_pkg::rss_settings_t settings;
  logic                   done;
  logic [31:0]            d;
  int                     errors       = 0;
  int                     total_checks = 0;
  int                     cycles       = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  rss_board rss_board_inst (.clk_sys_i(clk_sys_i), .mode_i(mode), .pull_up_i(pull_up),
    .pull_down_i(pull_down), .pin_o(pins));

  rss_top rss_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .port_power_control_i(pins[3:0]), .overcurrent_sense_i(pins[7:4]),
    .flash_data_out_i(pins[8]), .jtag_reset_i(pins[9]),
    .charge_port_global_disable_n_i(gdis_n), .strap_pull_up_o(pull_up),
    .strap_pull_down_o(pull_down), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .settings_o(settings), .sample_done_o(done));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Enough for seven sampling runs plus register traffic
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic check_set(input rss_pkg::rss_settings_t got, input rss_pkg::rss_settings_t exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: settings %h not %h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] stat_word(input rss_pkg::rss_settings_t e, input logic g);
    return {16'h0, g, 1'b1, e.smb_legacy, e.flash_fast, e.non_rem, e.chg_en, e.port_en};
  endfunction

  task automatic do_reset(input int n);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      @(negedge clk_sys_i);
      n++;
    end
    check_word({31'h0, done}, 32'h1);
    repeat (6) @(negedge clk_sys_i);
  endtask

  initial begin
    repeat (8) @(negedge clk_sys_i);
    check_word({30'h0, pull_up, pull_down}, 32'h2);
    check_set(settings, '0);
    do_reset(16);
    reg_read(rss_pkg::ADDR_CTRL, d);
    check_word(d, 32'h1);
    reg_read(4'h7, d);
    check_word(d, 32'h0);
    $display("test reset ended");
    foreach (ROWS[i]) begin
      @(posedge clk_sys_i);
      mode   <= ROWS[i].mode;
      gdis_n <= ROWS[i].gdis_n;
      do_reset(200);
      wait_done();
      reg_write(rss_pkg::ADDR_CTRL, {30'h0, ROWS[i].ctrl});
      repeat (6) @(negedge clk_sys_i);
      check_set(settings, ROWS[i].exp);
      reg_read(rss_pkg::ADDR_STAT, d);
      check_word(d, stat_word(ROWS[i].exp, ROWS[i].gdis_n));
      $display("test row %0d ended", i);
    end
    @(posedge clk_sys_i);
    gdis_n <= 1'b1;
    mode   <= 20'h55555;
    reg_write(rss_pkg::ADDR_STAT, 32'hffff_ffff);
    repeat (10) @(negedge clk_sys_i);
    check_set(settings, 15'h6ccf);
    reg_read(rss_pkg::ADDR_STAT, d);
    check_word(d, stat_word(15'h6ccf, 1'b1));
    reg_read(rss_pkg::ADDR_CTRL, d);
    check_word(d, 32'h1);
    // Read data stands one cycle; look in the cycle after it
    repeat (2) @(negedge clk_sys_i);
    check_word(rdata, 32'h0);
    $display("test hold ended");
    do_reset(200);
    repeat (250) @(negedge clk_sys_i);
    check_word({30'h0, pull_down, done}, 32'h2);
    check_set(settings, '0);
    mode <= 20'h00000;
    do_reset(200);
    wait_done();
    check_set(settings, 15'h7801);
    $display("test restart ended");
    end_of_test();
  end
endmodule
